// File: bpds_pkg.sv
// Constants, register map and helper functions of the bridge PWM output stage
package bpds_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_PERIOD = 12'h004;
    localparam logic [11:0] ADDR_DUTY = 12'h008;
    localparam logic [11:0] ADDR_ASD = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_POL_AC_BIT = 2;
    localparam int CTRL_POL_BD_BIT = 3;
    localparam int CTRL_DRV_BIT = 4;
    localparam int CTRL_W = 5;
    localparam int PER_PRESC_LSB = 8;
    localparam int ASD_STATUS_BIT = 7;
    localparam int ASD_SRC_LSB = 4;
    localparam int ASD_AC_LSB = 2;
    localparam int ASD_BD_LSB = 0;
    localparam int SRC_PIN_BIT = 0;
    localparam int SRC_CMP1_BIT = 1;
    localparam int SRC_CMP2_BIT = 2;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_DIR_BIT = 1;
    localparam int STAT_SWAP_BIT = 2;
    localparam int STAT_SD_BIT = 3;
    localparam int STAT_CNT_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [1:0] PRESC_RST = 2'h0;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [2:0] SRC_RST = 3'h0;
    localparam logic [1:0] PAIR_RST = 2'h0;
    localparam logic [7:0] CNT_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler terminal counts: divide by 1, 4, 16
    localparam logic [7:0] PRESC_MAX_1 = 8'h00;
    localparam logic [7:0] PRESC_MAX_4 = 8'h03;
    localparam logic [7:0] PRESC_MAX_16 = 8'h0F;

    // Pair shutdown states; code 2'h3 also means high impedance
    typedef enum logic [1:0] {
        BPDS_SD_LOW = 2'h0,
        BPDS_SD_HIGH = 2'h1,
        BPDS_SD_HIZ = 2'h2
    } bpds_sd_e;

    function automatic logic [7:0] bpds_presc_max(input logic [1:0] sel);
        logic [7:0] r;
        r = PRESC_MAX_16;
        if (sel == 2'h0) begin
            r = PRESC_MAX_1;
        end else if (sel == 2'h1) begin
            r = PRESC_MAX_4;
        end
        return r;
    endfunction

    function automatic logic bpds_sd_level(input logic [1:0] st);
        return st == BPDS_SD_HIGH;
    endfunction

    function automatic logic bpds_sd_hiz(input logic [1:0] st);
        return st[1];
    endfunction

endpackage

// File: bpds_sync.sv
// Two-stage synchroniser for the asynchronous shutdown inputs
`timescale 1ns/1ps
module bpds_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] async_in,
    input wire logic [2:0] rst_val,
    output logic [2:0] sync_out
);

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } bpds_sync_s;

    bpds_sync_s st_reg;
    bpds_sync_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.stage1 = async_in ^ rst_val;
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stage2 ^ rst_val;

endmodule // bpds_sync

// File: bpds_timer.sv
// Period timer with prescaler; marks the last count and the period wrap
`timescale 1ns/1ps
module bpds_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [7:0] period,
    input wire logic [1:0] presc_sel,
    output logic [7:0] count,
    output logic last_start,
    output logic wrap
);

    typedef struct packed {
        logic [7:0] pre_cnt;
        logic [7:0] count;
    } bpds_timer_s;

    bpds_timer_s st_reg;
    bpds_timer_s st_next;
    logic step;

    assign step = run && (st_reg.pre_cnt >= bpds_pkg::bpds_presc_max(presc_sel));
    assign wrap = step && (st_reg.count >= period);
    assign last_start = step && (wrap ? (period == 8'h00) : (st_reg.count + 8'h01 == period));
    assign count = st_reg.count;

    always_comb begin
        st_next = st_reg;
        if (!run) begin
            st_next.pre_cnt = bpds_pkg::CNT_RST;
            st_next.count = bpds_pkg::CNT_RST;
        end else if (step) begin
            st_next.pre_cnt = bpds_pkg::CNT_RST;
            st_next.count = wrap ? bpds_pkg::CNT_RST : st_reg.count + 8'h01;
        end else begin
            st_next.pre_cnt = st_reg.pre_cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // bpds_timer

// File: bpds_top.sv
// Full-bridge PWM output stage: direction change, polarity, auto-shutdown
//
// Overview of operation
// RULE1 - Direction bit picks forward or reverse; new value takes effect next cycle.
// RULE2 - On direction change, modulated outputs B and D go inactive before period end.
// RULE3 - On direction change, unmodulated A and C flip direction before period end.
// RULE4 - After a direction change, modulation of the new output resumes next period.
// RULE5 - Early switch lasts one prescale count of clock cycles before the boundary.
// RULE6 - Direction writes any time in the cycle leave the current waveform intact.
// RULE7 - No dead-band delay is inserted in full-bridge operation.
// RULE8 - Software should cut duty for one period before reversing at high duty.
// RULE9 - Polarity is chosen separately for the A/C pair and the B/D pair.
// RULE10 - Software sets polarity before enabling the pin drivers.
// RULE11 - Software enables PWM and waits one full cycle before enabling drivers.
// RULE12 - Period timer flag sets as each new period, hence the second, begins.
// RULE13 - Shutdown from selected sources: pin low, comparator one, two, or software.
// RULE14 - Shutdown status zero means normal running, one means shut down.
// RULE15 - Shutdown status is sticky until software clears it.
// RULE16 - A shutdown event forces enabled pins to shutdown levels without a clock.
// RULE17 - Each pair in shutdown drives high, low or high impedance per its field.
// RULE18 - Forward: A active, D modulated, B and C inactive.
// RULE19 - Reverse: C active, B modulated, A and D inactive.
// RULE20 - A mid-period direction write is held and used only at the next boundary.
`timescale 1ns/1ps
module bpds_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_int_pin_n,
    input wire logic comparator_one,
    input wire logic comparator_two,
    output logic bridge_out_a,
    output logic bridge_out_a_oe_n,
    output logic bridge_out_b,
    output logic bridge_out_b_oe_n,
    output logic bridge_out_c,
    output logic bridge_out_c_oe_n,
    output logic bridge_out_d,
    output logic bridge_out_d_oe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [bpds_pkg::CTRL_W-1:0] ctrl;
        logic [7:0] period;
        logic [1:0] presc;
        logic [7:0] duty;
        logic shutdown_event_status;
        logic [2:0] shutdown_source_sel;
        logic [1:0] pair_ac_shutdown_state;
        logic [1:0] pair_bd_shutdown_state;
        logic period_timer_flag;
        logic dir_applied;
        logic dir_target;
        logic swap;
        logic [3:0] level;
        logic [31:0] rdata;
        logic err;
    } bpds_top_s;

    bpds_top_s st_reg;
    bpds_top_s st_next;

    logic [7:0] tmr_count;
    logic tmr_last_start;
    logic tmr_wrap;
    logic [2:0] src_sync;
    logic apb_setup;
    logic apb_write;
    logic addr_ok;
    logic [31:0] cur_word;
    logic [31:0] new_word;
    logic [31:0] byte_mask;
    logic pwm_on;
    logic mod_on;
    logic dir_now;
    logic [3:0] raw;
    logic sync_event;
    logic async_event;
    logic force_sd;
    logic [3:0] pin_o;
    logic [3:0] pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Submodules
    bpds_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(pwm_on),
        .period(st_reg.period),
        .presc_sel(st_reg.presc),
        .count(tmr_count),
        .last_start(tmr_last_start),
        .wrap(tmr_wrap)
    );

    // Pin is active low, so its idle synchronised value is high
    bpds_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({comparator_two, comparator_one, ext_int_pin_n}),
        .rst_val(3'h1),
        .sync_out(src_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign pready = psel && penable;
    assign prdata = st_reg.rdata;
    assign pslverr = st_reg.err;
    assign addr_ok = (paddr == bpds_pkg::ADDR_CTRL) || (paddr == bpds_pkg::ADDR_PERIOD)
        || (paddr == bpds_pkg::ADDR_DUTY) || (paddr == bpds_pkg::ADDR_ASD)
        || (paddr == bpds_pkg::ADDR_STATUS);

    for (genvar i = 0; i < 4; i++) begin : g_mask
        assign byte_mask[i*8 +: 8] = {8{pstrb[i]}};
    end

    always_comb begin
        cur_word = 32'h0000_0000;
        unique case (paddr)
            bpds_pkg::ADDR_CTRL: begin
                cur_word[bpds_pkg::CTRL_W-1:0] = st_reg.ctrl;
            end
            bpds_pkg::ADDR_PERIOD: begin
                cur_word[7:0] = st_reg.period;
                cur_word[bpds_pkg::PER_PRESC_LSB +: 2] = st_reg.presc;
            end
            bpds_pkg::ADDR_DUTY: begin
                cur_word[7:0] = st_reg.duty;
            end
            bpds_pkg::ADDR_ASD: begin
                cur_word[bpds_pkg::ASD_STATUS_BIT] = st_reg.shutdown_event_status; // [RULE14]
                cur_word[bpds_pkg::ASD_SRC_LSB +: 3] = st_reg.shutdown_source_sel;
                cur_word[bpds_pkg::ASD_AC_LSB +: 2] = st_reg.pair_ac_shutdown_state;
                cur_word[bpds_pkg::ASD_BD_LSB +: 2] = st_reg.pair_bd_shutdown_state;
            end
            bpds_pkg::ADDR_STATUS: begin
                cur_word[bpds_pkg::STAT_FLAG_BIT] = st_reg.period_timer_flag;
                cur_word[bpds_pkg::STAT_DIR_BIT] = st_reg.dir_applied;
                cur_word[bpds_pkg::STAT_SWAP_BIT] = st_reg.swap;
                cur_word[bpds_pkg::STAT_SD_BIT] = sync_event || st_reg.shutdown_event_status;
                cur_word[bpds_pkg::STAT_CNT_LSB +: 8] = tmr_count;
            end
            default: begin
                cur_word = 32'h0000_0000;
            end
        endcase
    end

    assign new_word = (cur_word & ~byte_mask) | (pwdata & byte_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform and shutdown sources
    assign pwm_on = st_reg.ctrl[bpds_pkg::CTRL_EN_BIT];
    assign mod_on = tmr_count < st_reg.duty;
    assign dir_now = st_reg.dir_applied;

    always_comb begin
        raw = 4'h0;
        if (pwm_on) begin
            if (st_reg.swap) begin
                // Final prescale count: A/C take new direction, B/D held off [RULE2] [RULE3] [RULE5]
                raw[0] = !st_reg.dir_target;
                raw[2] = st_reg.dir_target;
            end else if (!dir_now) begin
                raw[0] = 1'b1; // [RULE18]
                raw[3] = mod_on;
            end else begin
                raw[2] = 1'b1; // [RULE19]
                raw[1] = mod_on;
            end
        end
    end

    assign sync_event =
        (st_reg.shutdown_source_sel[bpds_pkg::SRC_PIN_BIT] && !src_sync[0])
        || (st_reg.shutdown_source_sel[bpds_pkg::SRC_CMP1_BIT] && src_sync[1])
        || (st_reg.shutdown_source_sel[bpds_pkg::SRC_CMP2_BIT] && src_sync[2]); // [RULE13]

    // Unclocked path so a source trips the pins at once
    assign async_event =
        (st_reg.shutdown_source_sel[bpds_pkg::SRC_PIN_BIT] && !ext_int_pin_n)
        || (st_reg.shutdown_source_sel[bpds_pkg::SRC_CMP1_BIT] && comparator_one)
        || (st_reg.shutdown_source_sel[bpds_pkg::SRC_CMP2_BIT] && comparator_two); // [RULE16]
    assign force_sd = async_event || st_reg.shutdown_event_status; // [RULE16]

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.rdata = st_reg.rdata;
        st_next.err = st_reg.err;
        if (apb_setup) begin
            st_next.rdata = pwrite ? 32'h0000_0000 : cur_word;
            st_next.err = !addr_ok;
        end

        if (apb_write && addr_ok) begin
            unique case (paddr)
                bpds_pkg::ADDR_CTRL: begin
                    // Stored at once; direction bit applied only at a period boundary while enabled [RULE6] [RULE20]
                    st_next.ctrl = new_word[bpds_pkg::CTRL_W-1:0];
                end
                bpds_pkg::ADDR_PERIOD: begin
                    st_next.period = new_word[7:0];
                    st_next.presc = new_word[bpds_pkg::PER_PRESC_LSB +: 2];
                end
                bpds_pkg::ADDR_DUTY: begin
                    st_next.duty = new_word[7:0];
                end
                bpds_pkg::ADDR_ASD: begin
                    st_next.shutdown_event_status = new_word[bpds_pkg::ASD_STATUS_BIT]; // [RULE13]
                    st_next.shutdown_source_sel = new_word[bpds_pkg::ASD_SRC_LSB +: 3];
                    st_next.pair_ac_shutdown_state = new_word[bpds_pkg::ASD_AC_LSB +: 2];
                    st_next.pair_bd_shutdown_state = new_word[bpds_pkg::ASD_BD_LSB +: 2];
                end
                bpds_pkg::ADDR_STATUS: begin
                    if (new_word[bpds_pkg::STAT_FLAG_BIT]) begin
                        st_next.period_timer_flag = 1'b0;
                    end
                end
                default: begin
                    st_next.err = st_reg.err;
                end
            endcase
        end

        // Event set wins over a software clear [RULE15]
        if (sync_event) begin
            st_next.shutdown_event_status = 1'b1;
        end

        if (tmr_wrap) begin
            st_next.period_timer_flag = 1'b1; // [RULE12]
        end

        // Direction sequencing [RULE1]
        if (!pwm_on) begin
            st_next.dir_applied = st_reg.ctrl[bpds_pkg::CTRL_DIR_BIT];
            st_next.dir_target = st_reg.ctrl[bpds_pkg::CTRL_DIR_BIT];
            st_next.swap = 1'b0;
        end else begin
            if (tmr_wrap && st_reg.swap) begin
                st_next.dir_applied = st_reg.dir_target; // [RULE4]
                st_next.swap = 1'b0;
            end
            if (tmr_last_start) begin
                st_next.dir_target = st_reg.ctrl[bpds_pkg::CTRL_DIR_BIT]; // [RULE20]
                st_next.swap = st_reg.ctrl[bpds_pkg::CTRL_DIR_BIT]
                    != st_next.dir_applied; // [RULE5]
            end
        end

        // Straight polarity per pair, no dead band [RULE7] [RULE9]
        st_next.level[0] = raw[0] ^ st_reg.ctrl[bpds_pkg::CTRL_POL_AC_BIT];
        st_next.level[2] = raw[2] ^ st_reg.ctrl[bpds_pkg::CTRL_POL_AC_BIT];
        st_next.level[1] = raw[1] ^ st_reg.ctrl[bpds_pkg::CTRL_POL_BD_BIT];
        st_next.level[3] = raw[3] ^ st_reg.ctrl[bpds_pkg::CTRL_POL_BD_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.ctrl <= bpds_pkg::CTRL_RST;
            st_reg.period <= bpds_pkg::PERIOD_RST;
            st_reg.presc <= bpds_pkg::PRESC_RST;
            st_reg.duty <= bpds_pkg::DUTY_RST;
            st_reg.shutdown_event_status <= 1'b0;
            st_reg.shutdown_source_sel <= bpds_pkg::SRC_RST;
            st_reg.pair_ac_shutdown_state <= bpds_pkg::PAIR_RST;
            st_reg.pair_bd_shutdown_state <= bpds_pkg::PAIR_RST;
            st_reg.period_timer_flag <= 1'b0;
            st_reg.dir_applied <= 1'b0;
            st_reg.dir_target <= 1'b0;
            st_reg.swap <= 1'b0;
            st_reg.level <= 4'h0;
            st_reg.rdata <= 32'h0000_0000;
            st_reg.err <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin stage
    for (genvar i = 0; i < 4; i++) begin : g_pin
        logic [1:0] pair_state;
        assign pair_state = (i % 2 == 0) ? st_reg.pair_ac_shutdown_state
                                         : st_reg.pair_bd_shutdown_state;
        assign pin_o[i] = force_sd ? bpds_pkg::bpds_sd_level(pair_state)
                                   : st_reg.level[i]; // [RULE17]
        assign pin_oe_n[i] = !st_reg.ctrl[bpds_pkg::CTRL_DRV_BIT]
            || (force_sd && bpds_pkg::bpds_sd_hiz(pair_state)); // [RULE17]
    end

    assign bridge_out_a = pin_o[0];
    assign bridge_out_b = pin_o[1];
    assign bridge_out_c = pin_o[2];
    assign bridge_out_d = pin_o[3];
    assign bridge_out_a_oe_n = pin_oe_n[0];
    assign bridge_out_b_oe_n = pin_oe_n[1];
    assign bridge_out_c_oe_n = pin_oe_n[2];
    assign bridge_out_d_oe_n = pin_oe_n[3];

endmodule // bpds_top

// File: bpds_checker.sv
// Port-level assertions of the bridge PWM output stage
`timescale 1ns/1ps
module bpds_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_int_pin_n,
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic bridge_out_a,
    input wire logic bridge_out_a_oe_n,
    input wire logic bridge_out_b,
    input wire logic bridge_out_b_oe_n,
    input wire logic bridge_out_c,
    input wire logic bridge_out_c_oe_n,
    input wire logic bridge_out_d,
    input wire logic bridge_out_d_oe_n
);
    logic [7:0] ctrl_q;
    logic [7:0] asd_q;
    logic [1:0] ok_cnt;
    logic wr, ev, ok;
    assign wr = psel & penable & pwrite & pready;
    assign ev = (asd_q[4] & ~ext_int_pin_n) | (asd_q[5] & comparator_one)
        | (asd_q[6] & comparator_two);
    assign ok = ok_cnt == 2'h2;
    // Shadow of control fields; settle count after any write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            asd_q <= 8'h00;
            ok_cnt <= 2'h0;
        end else begin
            if (wr && paddr == bpds_pkg::ADDR_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end
            if (wr && paddr == bpds_pkg::ADDR_ASD) begin
                asd_q <= pwdata[7:0];
            end
            if (!(ctrl_q[0] & ctrl_q[4]) || asd_q[7:4] != 4'h0 || wr) begin
                ok_cnt <= 2'h0;
            end else if (!ok) begin
                ok_cnt <= ok_cnt + 2'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_zero: assert property (psel && penable |-> pready)
        else $error("pready missing in access phase");
    a_err_unmapped: assert property (psel && penable && paddr > bpds_pkg::ADDR_STATUS |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_mapped: assert property (psel && penable && paddr <= bpds_pkg::ADDR_STATUS
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access flagged");
    a_drv_off: assert property (!ctrl_q[4] |->
        bridge_out_a_oe_n && bridge_out_b_oe_n && bridge_out_c_oe_n && bridge_out_d_oe_n)
        else $error("pin driven while drivers off");
    a_sd_ac: assert property (ev && ctrl_q[4] |->
        (asd_q[3] ? bridge_out_a_oe_n && bridge_out_c_oe_n : !bridge_out_a_oe_n
        && !bridge_out_c_oe_n && bridge_out_a == asd_q[2] && bridge_out_c == asd_q[2]))
        else $error("pair ac not in shutdown state");
    a_sd_bd: assert property (ev && ctrl_q[4] |->
        (asd_q[1] ? bridge_out_b_oe_n && bridge_out_d_oe_n : !bridge_out_b_oe_n
        && !bridge_out_d_oe_n && bridge_out_b == asd_q[0] && bridge_out_d == asd_q[0]))
        else $error("pair bd not in shutdown state");
    a_ac_compl: assert property (ok |-> bridge_out_a != bridge_out_c
        && !bridge_out_a_oe_n && !bridge_out_c_oe_n) else $error("a and c not complementary");
    a_a_blocks_b: assert property (ok && bridge_out_a != ctrl_q[2] |->
        bridge_out_b == ctrl_q[3]) else $error("b active beside active a");
    a_c_blocks_d: assert property (ok && bridge_out_c != ctrl_q[2] |->
        bridge_out_d == ctrl_q[3]) else $error("d active beside active c");
    c_sd: cover property (ev && ctrl_q[4]);
    c_err: cover property (pslverr && pready);
    c_rev: cover property (ok && bridge_out_c != ctrl_q[2]);
endmodule // bpds_checker

// File: bpds_switch_model.sv
// Power switch driver model: bridge pads with external pull-downs
`timescale 1ns/1ps
module bpds_switch_model (
    input wire logic [3:0] drive,
    input wire logic [3:0] drive_oe_n,
    output logic [3:0] pad
);
    // Released pads are pulled low, keeping the switches off
    assign pad = ~drive_oe_n & drive;
endmodule // bpds_switch_model

// File: tb.sv
// Testbench of the bridge PWM output stage
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic ext_int_pin_n, comparator_one, comparator_two;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, drv, oe_n, pad;
    int errors, check_count;
    bpds_top bpds_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .ext_int_pin_n, .comparator_one, .comparator_two,
        .bridge_out_a(drv[0]), .bridge_out_a_oe_n(oe_n[0]), .bridge_out_b(drv[1]),
        .bridge_out_b_oe_n(oe_n[1]), .bridge_out_c(drv[2]), .bridge_out_c_oe_n(oe_n[2]),
        .bridge_out_d(drv[3]), .bridge_out_d_oe_n(oe_n[3]));
    bpds_switch_model bpds_switch_model_i (.drive(drv), .drive_oe_n(oe_n), .pad(pad));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 8) begin
            errors++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [11:0] addr, input logic [31:0] exp,
        input logic [31:0] mask = 32'hFFFFFFFF);
        apb(1'b0, addr, 32'h0);
        chk(name, rd & mask, exp);
    endtask
    task automatic wait_pad(input int idx, input logic lvl);
        int n;
        for (n = 0; n < 64; n++) begin
            @(negedge pclk);
            if (pad[idx] === lvl) break;
        end
        if (n == 64) begin
            errors++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("rst_oe", {28'h0, oe_n}, 32'hF);
        rdchk("ctrl", bpds_pkg::ADDR_CTRL, {27'h0, bpds_pkg::CTRL_RST});
        rdchk("per", bpds_pkg::ADDR_PERIOD, {22'h0, bpds_pkg::PRESC_RST, bpds_pkg::PERIOD_RST});
        rdchk("duty", bpds_pkg::ADDR_DUTY, {24'h0, bpds_pkg::DUTY_RST});
        rdchk("asd", bpds_pkg::ADDR_ASD, {24'h0, 1'b0, bpds_pkg::SRC_RST, bpds_pkg::PAIR_RST,
            bpds_pkg::PAIR_RST});
        rdchk("unmapped", 12'h020, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
    endtask
    task automatic t_flag();
        apb(1'b1, bpds_pkg::ADDR_PERIOD, 32'h103);
        apb(1'b1, bpds_pkg::ADDR_DUTY, 32'h3);
        apb(1'b1, bpds_pkg::ADDR_CTRL, 32'h1);
        rdchk("flag_first", bpds_pkg::ADDR_STATUS, 32'h0, 32'h1);
        repeat (16) @(posedge pclk);
        rdchk("flag_second", bpds_pkg::ADDR_STATUS, 32'h1, 32'h1);
    endtask
    task automatic t_dir(input logic pac, input logic pbd, input logic nd);
        logic [31:0] base, pr;
        int om, ou, len, act;
        base = {27'h0, 1'b1, pbd, pac, !nd, 1'b1};
        pr = 32'(nd ? bpds_pkg::PRESC_MAX_4 : bpds_pkg::PRESC_MAX_1) + 32'h1;
        om = nd ? 3 : 1;
        ou = nd ? 0 : 2;
        apb(1'b1, bpds_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, bpds_pkg::ADDR_PERIOD, {22'h0, 1'b0, nd, 8'h03});
        apb(1'b1, bpds_pkg::ADDR_CTRL, base & 32'hF);
        repeat (20) @(posedge pclk);
        apb(1'b1, bpds_pkg::ADDR_CTRL, base);
        wait_pad(om, pbd);
        wait_pad(om, !pbd);
        chk("old_unmod", {31'h0, pad[ou]}, {31'h0, !pac});
        apb(1'b1, bpds_pkg::ADDR_CTRL, base ^ 32'h2);
        @(negedge pclk);
        chk("mid_write", {31'h0, pad[ou]}, {31'h0, !pac});
        wait_pad(2 - ou, !pac);
        chk("swap_ou", {30'h0, pad[ou], pad[om]}, {30'h0, pac, pbd});
        len = 0;
        while (pad[4 - om] === pbd && len < 64) begin
            len++;
            @(negedge pclk);
        end
        chk("swap_len", len, pr);
        act = 0;
        while (pad[4 - om] === !pbd && act < 64) begin
            act++;
            @(negedge pclk);
        end
        chk("new_duty", act, 32'h3 * pr);
    endtask
    task automatic t_sd();
        logic [1:0] ac, bd;
        logic [7:0] cfg;
        for (int i = 0; i < 4; i++) begin
            ac = 2'(i);
            bd = 2'(i + 2);
            cfg = {1'b0, i == 2, i == 1, i == 0, ac, bd};
            apb(1'b1, bpds_pkg::ADDR_ASD, {24'h0, cfg});
            @(posedge pclk);
            ext_int_pin_n <= i != 0;
            comparator_one <= i == 1;
            comparator_two <= i == 2;
            if (i == 3) begin
                apb(1'b1, bpds_pkg::ADDR_ASD, {24'h0, cfg | 8'h80});
            end
            @(negedge pclk);
            chk("sd_oe", {28'h0, oe_n}, {28'h0, bd[1], ac[1], bd[1], ac[1]});
            chk("sd_pad", {28'h0, pad}, {28'h0, bd == 2'h1, ac == 2'h1, bd == 2'h1,
                ac == 2'h1});
            repeat (4) @(posedge pclk);
            rdchk("sd_set", bpds_pkg::ADDR_ASD, 32'h80, 32'h80);
            ext_int_pin_n <= 1'b1;
            comparator_one <= 1'b0;
            comparator_two <= 1'b0;
            repeat (4) @(posedge pclk);
            rdchk("sd_stay", bpds_pkg::ADDR_ASD, 32'h80, 32'h80);
            apb(1'b1, bpds_pkg::ADDR_ASD, {24'h0, cfg});
            rdchk("sd_clr", bpds_pkg::ADDR_ASD, 32'h0, 32'h80);
        end
    endtask
    initial begin
        errors = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        ext_int_pin_n = 1'b1;
        comparator_one = 1'b0;
        comparator_two = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flag();
        t_dir(1'b1, 1'b0, 1'b1);
        t_dir(1'b0, 1'b1, 1'b0);
        t_sd();
        end_sim();
    end
endmodule // tb
bind bpds_top bpds_checker bpds_checker_i (.*);
